// *** inc/etsc_pkg.sv ***
// Summary of operation
// - counter reset works only when pin function select picks counter reset use
// - rising pulse on the event pin clears the counter; low level does nothing
// - 16-bit up counter ticks at 62.5 kHz, one count per 16 us
// - entering sampling mode from configuration mode starts the counter at zero
// - a reset pulse clears the counter, which then counts up again from zero
// - counter or sample count copied into count register at sample completion, before data ready
// - leaving sampling mode for configuration mode stops the counter
// - counter wraps from 65535 to zero and keeps counting
// - in counter reset mode the count register holds the timestamp counter
// - pulse to completion delay equals count times 16 us within 150 us
// - otherwise the count register holds a sample counter, one per 500 us
// - data ready sets on sample completion and clears when the sample is read
package etsc_pkg;
   // ==========================================================
   // register map, word indices; byte address is four times index
   localparam logic [7:0] IDX_MISC_CONTROL = 8'h02;
   localparam logic [7:0] IDX_STATUS = 8'h04;
   localparam logic [7:0] IDX_SAMPLE_DATA = 8'h06;
   localparam logic [7:0] IDX_SAMPLE_TIMESTAMP = 8'h0a;
   localparam logic [11:0] ADDR_MISC_CONTROL = {2'b00, IDX_MISC_CONTROL, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [11:0] ADDR_SAMPLE_DATA = {2'b00, IDX_SAMPLE_DATA, 2'b00};
   localparam logic [11:0] ADDR_SAMPLE_TIMESTAMP = {2'b00, IDX_SAMPLE_TIMESTAMP, 2'b00};
   // ==========================================================
   // misc control fields
   localparam int MODE_BIT = 0;
   localparam int SEL_LSB = 6;
   localparam int SEL_MSB = 7;
   localparam logic [1:0] SEL_GPIO = 2'b00;
   localparam logic [1:0] SEL_COUNTER_RESET = 2'b01;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_NS = 16000;
   localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_PERIOD_NS = 500000;
   localparam int SAMPLE_CYC_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   // ==========================================================
   typedef enum logic [1:0] {
      ETSC_CONFIG = 2'b01,
      ETSC_SAMPLING = 2'b10
   } etsc_mode_e;
endpackage : etsc_pkg

// *** src/etsc_counter.sv ***
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module etsc_counter
   import etsc_pkg::*;
#(
   parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_event_pin,
   input wire logic [15:0] sensorValue,
   output logic dataReady
);
   localparam int DIV_W = $clog2(SAMPLE_CYC + 1);
   localparam int TICK_W = $clog2(TICK_CYC + 1);

   // ==========================================================
   // state
   etsc_mode_e mode_q;
   logic [1:0] pinSel_q;
   logic extMeta_q;
   logic extSync_q;
   logic extPrev_q;
   logic [TICK_W-1:0] tickDiv_q;
   logic [TICK_W-1:0] tickDiv_d;
   logic [15:0] tsCount_q;
   logic [15:0] tsCount_d;
   logic [DIV_W-1:0] sampleDiv_q;
   logic [DIV_W-1:0] sampleDiv_d;
   logic [15:0] sampleCount_q;
   logic [15:0] timestampReg_q;
   logic [15:0] sampleReg_q;
   logic drdyPend_q;
   logic dataReady_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // ==========================================================
   // bus decode
   wire apbAccess = psel & penable & ~pready_q;
   wire apbCommit = psel & penable & pready_q;
   wire hitCtrl = (paddr == ADDR_MISC_CONTROL);
   wire hitStatus = (paddr == ADDR_STATUS);
   wire hitData = (paddr == ADDR_SAMPLE_DATA);
   wire hitCount = (paddr == ADDR_SAMPLE_TIMESTAMP);
   wire hitAny = hitCtrl | hitStatus | hitData | hitCount;
   wire ctrlWrite = apbCommit & pwrite & hitCtrl;
   wire dataRead = apbCommit & ~pwrite & hitData;
   wire sampling = (mode_q == ETSC_SAMPLING);
   wire startSampling = ctrlWrite & pwdata[MODE_BIT] & ~sampling;
   wire [31:0] ctrlView = {24'h0000_00, pinSel_q, 5'h00, sampling};
   wire [31:0] statusView = {30'h0000_0000, sampling, dataReady_q};
   wire [31:0] readMux = hitCtrl ? ctrlView :
                         hitStatus ? statusView :
                         hitData ? {16'h0000, sampleReg_q} :
                         hitCount ? {16'h0000, timestampReg_q} : 32'h0000_0000;

   // ==========================================================
   // event pin and timing
   // the pulse may be as short as 100 ns; two cycles at 20 MHz still catch it
   wire counterMode = (pinSel_q == SEL_COUNTER_RESET);
   wire extEdge = extSync_q & ~extPrev_q;
   wire extClear = extEdge & counterMode & sampling;
   wire tickEnd = (tickDiv_q == TICK_W'(TICK_CYC - 1));
   wire sampleDone = sampling & (sampleDiv_q == DIV_W'(SAMPLE_CYC - 1));
   wire [15:0] latchValue = counterMode ? tsCount_q : sampleCount_q + 16'h0001;

   always_comb begin
      tsCount_d = tsCount_q;
      tickDiv_d = tickDiv_q;
      if (startSampling || extClear) begin
         tsCount_d = COUNT_RESET;
         tickDiv_d = '0;
      end else if (sampling) begin
         tickDiv_d = tickEnd ? '0 : tickDiv_q + TICK_W'(1);
         if (tickEnd) begin
            tsCount_d = tsCount_q + 16'h0001;
         end
      end
   end

   // sample completion cadence; restarts with each sampling session
   assign sampleDiv_d = (!sampling || sampleDone) ? '0 : sampleDiv_q + DIV_W'(1);

   // ==========================================================
   // mode and control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= ETSC_CONFIG;
         pinSel_q <= SEL_GPIO;
      end else if (ctrlWrite) begin
         pinSel_q <= pwdata[SEL_MSB:SEL_LSB];
         unique case (pwdata[MODE_BIT])
            1'b1: mode_q <= ETSC_SAMPLING;
            1'b0: mode_q <= ETSC_CONFIG;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extMeta_q <= 1'b0;
         extSync_q <= 1'b0;
         extPrev_q <= 1'b0;
      end else begin
         extMeta_q <= external_event_pin;
         extSync_q <= extMeta_q;
         extPrev_q <= extSync_q;
      end
   end

   // counter holds its value outside sampling mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tsCount_q <= COUNT_RESET;
         tickDiv_q <= '0;
         sampleDiv_q <= '0;
      end else begin
         tsCount_q <= tsCount_d;
         tickDiv_q <= tickDiv_d;
         sampleDiv_q <= sampleDiv_d;
      end
   end

   // ==========================================================
   // sample latch and data ready
   // data ready is delayed a cycle so the count register is settled first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sampleCount_q <= COUNT_RESET;
         timestampReg_q <= COUNT_RESET;
         sampleReg_q <= 16'h0000;
         drdyPend_q <= 1'b0;
      end else begin
         drdyPend_q <= sampleDone;
         if (sampleDone) begin
            sampleCount_q <= sampleCount_q + 16'h0001;
            timestampReg_q <= latchValue;
            sampleReg_q <= sensorValue;
         end
      end
   end

   // a new sample in the cycle the old one is read keeps data ready set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataReady_q <= 1'b0;
      end else if (drdyPend_q) begin
         dataReady_q <= 1'b1;
      end else if (dataRead) begin
         dataReady_q <= 1'b0;
      end
   end

   // ==========================================================
   // apb answer: one wait state, unmapped addresses error
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= apbAccess;
         pslverr_q <= apbAccess & ~hitAny;
         if (apbAccess && !pwrite) begin
            prdata_q <= readMux;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign dataReady = dataReady_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sel_gate_a: assert property (
      !counterMode && sampling && !tickEnd && !startSampling |=> $stable(tsCount_q))
      else $error("counter disturbed while pin is not in counter reset use");
   low_level_a: assert property (
      sampling && !extEdge && !tickEnd && !startSampling |=> tsCount_q == $past(tsCount_q))
      else $error("counter changed without tick or rising pulse");
   tick_step_a: assert property (
      sampling && tickEnd && !extClear && !startSampling
      |=> tsCount_q == $past(tsCount_q) + 16'h0001)
      else $error("counter missed its tick");
   start_zero_a: assert property (
      startSampling |=> tsCount_q == COUNT_RESET && sampling)
      else $error("sampling start did not zero the counter");
   ext_clear_a: assert property (
      extClear |=> tsCount_q == COUNT_RESET ##1 tsCount_q == COUNT_RESET)
      else $error("reset pulse did not clear the counter");
   latch_first_a: assert property (
      sampleDone |=> !$rose(dataReady_q) ##1 dataReady_q)
      else $error("data ready not one cycle after count latch");
   config_hold_a: assert property (
      !sampling && !startSampling |=> $stable(tsCount_q))
      else $error("counter moved in configuration mode");
   wrap_zero_a: assert property (
      sampling && tickEnd && !extClear && tsCount_q == 16'hffff |=> tsCount_q == 16'h0000)
      else $error("counter did not wrap to zero");
   stamp_latch_a: assert property (
      sampleDone && counterMode |=> timestampReg_q == $past(tsCount_q))
      else $error("count register missed the timestamp");
   plain_count_a: assert property (
      sampleDone && !counterMode |=> timestampReg_q == $past(sampleCount_q) + 16'h0001)
      else $error("count register missed the sample count");
   drdy_clear_a: assert property (
      dataRead && !drdyPend_q |=> !dataReady_q)
      else $error("data ready stuck after sample read");
   one_edge_a: assert property (
      extEdge |=> !extEdge [*2])
      else $error("one pulse detected twice");
   bus_answer_a: assert property (
      apbAccess |=> pready_q ##1 !pready_q)
      else $error("apb answer not one wait state");

   // ==========================================================
   // bus and register view checks
   err_unmapped_a: assert property (
      apbAccess && !hitAny |=> pslverr_q && pready_q)
      else $error("unmapped access answered without error");
   err_mapped_a: assert property (
      apbAccess && hitAny |=> !pslverr_q)
      else $error("mapped access answered with error");
   write_hold_a: assert property (
      apbAccess && pwrite |=> $stable(prdata_q))
      else $error("read data moved on a write");
   count_read_a: assert property (
      apbAccess && !pwrite && hitCount |=> prdata_q == {16'h0000, $past(timestampReg_q)})
      else $error("count register read returned wrong value");
   data_read_a: assert property (
      apbAccess && !pwrite && hitData |=> prdata_q == {16'h0000, $past(sampleReg_q)})
      else $error("sample data read returned wrong value");
   status_read_a: assert property (
      apbAccess && !pwrite && hitStatus
      |=> prdata_q == {30'h0000_0000, $past(sampling), $past(dataReady_q)})
      else $error("status read returned wrong value");
   sel_on_a: assert property (
      ctrlWrite && pwdata[SEL_MSB:SEL_LSB] == SEL_COUNTER_RESET |=> counterMode)
      else $error("counter reset use not taken from the write");
   sel_off_a: assert property (
      ctrlWrite && pwdata[SEL_MSB:SEL_LSB] != SEL_COUNTER_RESET |=> !counterMode)
      else $error("counter reset use kept after another selection");
   mode_stop_a: assert property (
      ctrlWrite && !pwdata[MODE_BIT] |=> !sampling)
      else $error("configuration mode not entered");
   mode_go_a: assert property (
      ctrlWrite && pwdata[MODE_BIT] |=> sampling)
      else $error("sampling mode not entered");
   mode_legal_a: assert property (
      mode_q == ETSC_CONFIG || mode_q == ETSC_SAMPLING)
      else $error("mode register left its one-hot codes");

   // ==========================================================
   // timing and sample checks
   // a clear also restarts the divider so the first count after it is a full 16 us
   clear_tick_a: assert property (
      extClear |=> tickDiv_q == '0)
      else $error("reset pulse left the tick divider running");
   tick_range_a: assert property (
      tickDiv_q <= TICK_W'(TICK_CYC - 1))
      else $error("tick divider past its end");
   config_tick_a: assert property (
      !sampling && !startSampling |=> $stable(tickDiv_q))
      else $error("tick divider moved in configuration mode");
   sample_range_a: assert property (
      sampleDiv_q <= DIV_W'(SAMPLE_CYC - 1))
      else $error("sample divider past its end");
   idle_cadence_a: assert property (
      !sampling |=> sampleDiv_q == '0)
      else $error("sample cadence not restarted outside sampling");
   sample_count_a: assert property (
      sampleDone |=> sampleCount_q == $past(sampleCount_q) + 16'h0001)
      else $error("sample counter missed a completion");
   count_hold_a: assert property (
      !sampleDone |=> $stable(sampleCount_q))
      else $error("sample counter moved without a completion");
   stamp_hold_a: assert property (
      !sampleDone |=> $stable(timestampReg_q))
      else $error("count register moved between completions");
   capture_value_a: assert property (
      sampleDone |=> sampleReg_q == $past(sensorValue))
      else $error("sample data not captured at completion");
   drdy_set_a: assert property (
      drdyPend_q |=> dataReady_q)
      else $error("data ready not set after a completion");
   drdy_hold_a: assert property (
      dataReady_q && !dataRead |=> dataReady_q)
      else $error("data ready dropped before the sample was read");
   drdy_cause_a: assert property (
      $rose(dataReady_q) |-> $past(drdyPend_q))
      else $error("data ready rose without a latched count");

   clear_seen_c: cover property (extClear ##[1:400] tickEnd);
   wrap_seen_c: cover property (tsCount_q == 16'hffff && tickEnd && sampling);
   drdy_read_c: cover property ($rose(dataReady_q) ##[1:20] dataRead);
   bad_addr_c: cover property (pslverr_q);
   pin_ignored_c: cover property (extEdge && !counterMode && sampling);
endmodule : etsc_counter
`default_nettype wire

// *** sim/etsc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side: reset pulses on the event pin
module etsc_host_model #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic fire,
   output logic external_event_pin
);
   int left = 0;
   // 4 cycles is 200 ns, wide enough for the 2-flop sync; spacing is the caller's duty
   always @(posedge clk) begin
      if (fire) left <= WIDTH;
      else if (left > 0) left <= left - 1;
      external_event_pin <= fire || left > 1;
   end
endmodule : etsc_host_model
`default_nettype wire

// *** sim/etsc_counter_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module etsc_counter_tb
   import etsc_pkg::*;
();
   typedef struct {
      logic [31:0] lo;
      logic [31:0] hi;
      logic err;
   } etsc_note_s;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, dataReady, fire, extPin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] sensorValue;
   etsc_note_s q[$];
   etsc_note_s e;
   int seed = 32'h16de;
   int numErrors = 0;
   int nCompared = 0;
   int cyc = 0;
   int nDone = 0;
   int ref0, refB;
   etsc_counter #(.SAMPLE_CYC(100)) etsc_counter_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_event_pin(extPin),
      .sensorValue(sensorValue), .dataReady(dataReady));
   etsc_host_model etsc_host_model_inst (.clk(clk), .fire(fire), .external_event_pin(extPin));
   // ==========================================
   // checking
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic finalReport();
      if (numErrors == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finalReport
   // range notes let timestamps allow for sync and tick phase
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (psel && penable && pready === 1'b1) begin
         e = q.pop_front();
         check("pslverr", {31'b0, pslverr}, {31'b0, e.err});
         check("prdata", (prdata >= e.lo && prdata <= e.hi) === 1'b1 ? e.lo : prdata, e.lo);
      end
   end
   // ==========================================
   // apb master
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, etsc_note_s n);
      int k;
      @(posedge clk);
      q.push_back(n);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(logic [11:0] a, logic [31:0] lo, logic [31:0] hi);
      apb(1'b0, a, 32'h0000_0000, '{lo, hi, 1'b0});
   endtask : rd
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, '{32'h0000_0000, 32'hffff_ffff, 1'b0});
   endtask : wr
   task automatic pulse();
      @(posedge clk) fire <= 1'b1;
      @(posedge clk) fire <= 1'b0;
      ref0 = cyc;
   endtask : pulse
   // r below zero means the plain sample count is expected
   task automatic samp(int r);
      int k;
      int c;
      k = 0;
      while (dataReady !== 1'b1 && k < 400) begin
         @(posedge clk);
         k++;
      end
      nDone++;
      c = (cyc - r) / TICK_CYC;
      rd(ADDR_STATUS, 3, 3);
      if (r < 0) rd(ADDR_SAMPLE_TIMESTAMP, nDone, nDone);
      else rd(ADDR_SAMPLE_TIMESTAMP, c > 0 ? c - 1 : 0, c + 1);
      rd(ADDR_SAMPLE_DATA, {16'h0000, sensorValue}, {16'h0000, sensorValue});
      rd(ADDR_STATUS, 2, 2);
      sensorValue <= 16'($random(seed));
   endtask : samp
   // ==========================================
   // sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      numErrors++;
      finalReport();
   end
   initial begin
      {psel, penable, pwrite, fire, rst_n} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      sensorValue = 16'($random(seed));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(ADDR_MISC_CONTROL, 0, 0);
      rd(ADDR_STATUS, 0, 0);
      rd(ADDR_SAMPLE_TIMESTAMP, 0, 0);
      apb(1'b0, 12'h03c, 32'h0000_0000, '{32'h0000_0000, 32'h0000_0000, 1'b1});
      wr(ADDR_MISC_CONTROL, 32'hffff_ff40);
      rd(ADDR_MISC_CONTROL, 32'h0000_0040, 32'h0000_0040);
      wr(ADDR_MISC_CONTROL, 32'h0000_0041);
      ref0 = cyc;
      for (int i = 0; i < 230; i++) begin
         if (i == 10 || i == 220) pulse();
         samp(ref0);
      end
      wr(ADDR_MISC_CONTROL, 32'h0000_0040);
      rd(ADDR_STATUS, 0, 0);
      // pin ignored while the pin serves as gpio
      wr(ADDR_MISC_CONTROL, 32'h0000_0001);
      refB = cyc;
      for (int j = 0; j < 210; j++) begin
         if (j == 200) pulse();
         samp(-1);
      end
      wr(ADDR_MISC_CONTROL, 32'h0000_0041);
      for (int j = 0; j < 10; j++) samp(refB);
      finalReport();
   end
endmodule : etsc_counter_tb
`default_nettype wire
